// File: unc_err_pkg.sv
/*
 holds offsets, field positions, reset values and timing counts of the
 uncorrectable error status and mask bank.
 assumes a configuration access port of 32-bit words at byte offsets.
*/
package unc_err_pkg;
   // =====================================================
   // register offsets
   localparam logic [11:0] flags_offset = 12'h104;
   localparam logic [11:0] masks_offset = 12'h108;

   // =====================================================
   // bit positions
   localparam int unsigned unsupported_request_pos    = 20;
   localparam int unsigned end_to_end_crc_pos         = 19;
   localparam int unsigned malformed_packet_pos       = 18;
   localparam int unsigned receiver_overflow_pos      = 17;
   localparam int unsigned unexpected_completion_pos  = 16;
   localparam int unsigned completer_abort_pos        = 15;
   localparam int unsigned completion_timeout_pos     = 14;
   localparam int unsigned flow_control_error_pos     = 13;
   localparam int unsigned poisoned_packet_pos        = 12;
   localparam int unsigned link_protocol_error_pos    = 4;
   localparam int unsigned training_error_pos         = 0;

   // implemented sticky bits: 20, 18..12, 4
   localparam logic [31:0] implemented_bits = 32'h0017_f010;
   localparam logic [31:0] flags_reset      = 32'h0000_0000;
   localparam logic [31:0] masks_reset      = 32'h0000_0000;

   // =====================================================
   // completion timeout window: least 16 ms
   localparam longint unsigned timeout_min_ms   = 16;
   localparam longint unsigned timeout_max_ms   = 32;
   localparam longint unsigned clk_hz           = 200_000_000;
   localparam longint unsigned timeout_cycles   = (timeout_min_ms * clk_hz + 999) / 1000;
   localparam int unsigned     tmo_width        = 23;
endpackage

// File: unc_err_timer.sv
/*
 holds one completion timeout watchdog for an outstanding inbound read.
 assumes start and done are single-cycle pulses from the completion tracker.
*/
`timescale 1ns/1ps
`default_nettype none
module unc_err_timer
   import unc_err_pkg::*;
#(
   parameter logic [tmo_width-1:0] limit = tmo_width'(timeout_cycles)
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // control
   input  wire logic start,
   input  wire logic done,
   // result
   output logic      expired
);
   logic [tmo_width-1:0] count_ff;
   logic                 busy_ff;
   logic [tmo_width-1:0] nxt_count;
   logic                 nxt_busy;
   logic                 hit;

   // =====================================================
   // watchdog
   always_comb begin
      nxt_count = count_ff;
      nxt_busy  = busy_ff;
      hit       = 1'b0;
      if (start) begin
         nxt_busy  = 1'b1;
         nxt_count = '0;
      end else if (done) begin
         nxt_busy = 1'b0;
      end else if (busy_ff) begin
         if (count_ff == limit - tmo_width'(1)) begin
            hit      = 1'b1;
            nxt_busy = 1'b0;
         end else begin
            nxt_count = count_ff + tmo_width'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
         busy_ff  <= 1'b0;
         expired  <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         busy_ff  <= nxt_busy;
         expired  <= hit;
      end
   end
endmodule
`default_nettype wire

// File: unc_err_bank.sv
/*
 holds the uncorrectable error status and mask registers, the report,
 header-capture and first-error-pointer qualifiers.
 assumes nrst is the power-on reset only; link and hot resets do not reach
 this block. assumes error inputs are single-cycle pulses on clk.
*/
// Function
// - hardware sets bits; write one clears
// - unsupported request, hot plug included, sets 20
// - bit 19 never set
// - malformed packet sets 18, logs header
// - receive overflow sets 17
// - unexpected completion sets 16, logs header
// - completer abort sets 15, logs header
// - read timeout 16-32 ms sets 14
// - flow control error sets 13
// - poisoned packet sets 12, logs header
// - link protocol error sets 4
// - training error bit reads zero
// - both registers reset to zero
// - masked errors send no error message
// - masked errors skip log, pointer; status sets
// - mask bits sticky read-write, others zero
// - severity one fatal, zero non-fatal
`timescale 1ns/1ps
`default_nettype none
module unc_err_bank
   import unc_err_pkg::*;
#(
   // watchdog length; a bench may shorten it to reach the timeout quickly
   parameter logic [tmo_width-1:0] timeout_limit = tmo_width'(timeout_cycles)
) (
   // clock and power-on reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // configuration access
   input  wire logic [11:0] cfg_addr,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   // error sources
   input  wire logic        rx_unsupported_request,
   input  wire logic        hp_unsupported_request,
   input  wire logic        rx_malformed_packet,
   input  wire logic        rx_buffer_overflow,
   input  wire logic        cpl_bad_requester,
   input  wire logic        cpl_bad_tag,
   input  wire logic        hp_completer_abort,
   input  wire logic        read_issued,
   input  wire logic        read_completed,
   input  wire logic        fc_protocol_error,
   input  wire logic        rx_poisoned_packet,
   input  wire logic        dl_protocol_error,
   // severity from the neighbouring register
   input  wire logic [31:0] severity,
   // reporting and logging
   output logic             send_fatal,
   output logic             send_nonfatal,
   output logic             log_header,
   output logic             update_first_error,
   output logic [4:0]       first_error_index
);
   logic [31:0] flags_ff;
   logic [31:0] masks_ff;
   logic [31:0] nxt_flags;
   logic [31:0] nxt_masks;
   logic [31:0] events;
   logic [31:0] loggable;
   logic [31:0] wmask;
   logic [31:0] unmasked;
   logic [31:0] logged;
   logic        timeout_hit;
   logic        wr_flags;
   logic        wr_masks;
   logic [4:0]  nxt_index;
   logic        nxt_fatal;
   logic        nxt_nonfatal;

   // =====================================================
   // completion timeout
   unc_err_timer #(
      .limit   (timeout_limit)
   ) u_timer (
      .clk     (clk),
      .nrst    (nrst),
      .start   (read_issued),
      .done    (read_completed),
      .expired (timeout_hit)
   );

   // =====================================================
   // event vector
   always_comb begin
      events = '0;
      events[unsupported_request_pos]   = rx_unsupported_request | hp_unsupported_request;
      events[end_to_end_crc_pos]        = 1'b0;
      events[malformed_packet_pos]      = rx_malformed_packet;
      events[receiver_overflow_pos]     = rx_buffer_overflow;
      events[unexpected_completion_pos] = cpl_bad_requester | cpl_bad_tag;
      events[completer_abort_pos]       = hp_completer_abort;
      events[completion_timeout_pos]    = timeout_hit;
      events[flow_control_error_pos]    = fc_protocol_error;
      events[poisoned_packet_pos]       = rx_poisoned_packet;
      events[link_protocol_error_pos]   = dl_protocol_error;
      events[training_error_pos]        = 1'b0;
      loggable = '0;
      loggable[malformed_packet_pos]      = 1'b1;
      loggable[unexpected_completion_pos] = 1'b1;
      loggable[completer_abort_pos]       = 1'b1;
      loggable[poisoned_packet_pos]       = 1'b1;
   end

   // =====================================================
   // register writes
   always_comb begin
      wmask    = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
      wr_flags = cfg_wr && (cfg_addr == flags_offset);
      wr_masks = cfg_wr && (cfg_addr == masks_offset);
      nxt_flags = flags_ff;
      nxt_masks = masks_ff;
      if (wr_flags) begin
         nxt_flags = flags_ff & ~(cfg_wdata & wmask);
      end
      if (wr_masks) begin
         nxt_masks = (masks_ff & ~wmask) | (cfg_wdata & wmask);
      end
      // a new event beats a same-cycle clear
      nxt_flags = (nxt_flags | events) & implemented_bits;
      nxt_masks = nxt_masks & implemented_bits;
   end

   // =====================================================
   // report qualifiers
   always_comb begin
      unmasked     = events & ~masks_ff & implemented_bits;
      logged       = unmasked & loggable;
      nxt_fatal    = |(unmasked & severity);
      nxt_nonfatal = |(unmasked & ~severity);
      // lowest set position wins when several arrive together
      nxt_index = first_error_index;
      for (int i = 31; i >= 0; i--) begin
         if (unmasked[i]) begin
            nxt_index = 5'(i);
         end
      end
   end

   // sticky state: power-on reset is the only reset that clears it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags_ff           <= flags_reset;
         masks_ff           <= masks_reset;
         send_fatal         <= 1'b0;
         send_nonfatal      <= 1'b0;
         log_header         <= 1'b0;
         update_first_error <= 1'b0;
         first_error_index  <= 5'h00;
         cfg_rdata          <= 32'h0000_0000;
      end else begin
         flags_ff           <= nxt_flags;
         masks_ff           <= nxt_masks;
         send_fatal         <= nxt_fatal;
         send_nonfatal      <= nxt_nonfatal;
         log_header         <= |logged;
         update_first_error <= |unmasked;
         first_error_index  <= nxt_index;
         if (cfg_rd && cfg_addr == flags_offset) begin
            cfg_rdata <= flags_ff;
         end else if (cfg_rd && cfg_addr == masks_offset) begin
            cfg_rdata <= masks_ff;
         end else begin
            cfg_rdata <= 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

// File: unc_err_host.sv
/* host bridge model: counts the error messages and header captures.
   assumes one-cycle pulses on clk from the bank. */
`timescale 1ns/1ps
`default_nettype none
module unc_err_host (
   // from the bank
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        send_fatal,
   input  wire logic        send_nonfatal,
   input  wire logic        log_header,
   // running totals
   output logic [31:0]      n_fatal,
   output logic [31:0]      n_nonfatal,
   output logic [31:0]      n_log
);
   // ==========
   // message intake
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         n_fatal <= 32'h0;
         n_nonfatal <= 32'h0;
         n_log <= 32'h0;
      end else begin
         n_fatal <= n_fatal + 32'(send_fatal);
         n_nonfatal <= n_nonfatal + 32'(send_nonfatal);
         n_log <= n_log + 32'(log_header);
      end
   end
endmodule
`default_nettype wire

// File: unc_err_bank_chk.sv
/* checker for the error bank ports.
   assumes binding onto unc_err_bank. */
`timescale 1ns/1ps
`default_nettype none
module unc_err_bank_chk
   import unc_err_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // configuration access
   input wire logic        cfg_rd,
   input wire logic [31:0] cfg_rdata,
   // logged error sources
   input wire logic        rx_malformed_packet,
   input wire logic        cpl_bad_requester,
   input wire logic        cpl_bad_tag,
   input wire logic        hp_completer_abort,
   input wire logic        rx_poisoned_packet,
   // reporting
   input wire logic [31:0] severity,
   input wire logic        send_fatal,
   input wire logic        send_nonfatal,
   input wire logic        log_header,
   input wire logic        update_first_error,
   input wire logic [4:0]  first_error_index
);
   // ==========
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_rd_done;
      cfg_rd ##1 1'b1;
   endsequence
   property p_idle_rd; !$past(cfg_rd) |-> cfg_rdata == 32'h0; endproperty
   property p_rd_resv; s_rd_done |-> (cfg_rdata & ~implemented_bits) == 32'h0; endproperty
   property p_log_src;
      log_header |-> $past(rx_malformed_packet || cpl_bad_requester || cpl_bad_tag
                           || hp_completer_abort || rx_poisoned_packet);
   endproperty
   property p_fat_sev; send_fatal |-> $past(severity) != 32'h0; endproperty
   property p_nf_sev; send_nonfatal |-> $past(severity) != 32'hffff_ffff; endproperty
   property p_rep_upd; send_fatal || send_nonfatal |-> update_first_error; endproperty
   property p_upd_rep; update_first_error |-> send_fatal || send_nonfatal; endproperty
   property p_log_upd; log_header |-> update_first_error; endproperty
   property p_idx_hold; !update_first_error |-> $stable(first_error_index); endproperty
   property p_idx_legal; update_first_error |-> implemented_bits[first_error_index]; endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("read data not idle");
   a_rd_resv: assert property (p_rd_resv) else $error("reserved bit read one");
   a_log_src: assert property (p_log_src) else $error("capture without cause");
   a_fat_sev: assert property (p_fat_sev) else $error("fatal without severity");
   a_nf_sev: assert property (p_nf_sev) else $error("nonfatal with all severe");
   a_rep_upd: assert property (p_rep_upd) else $error("report without pointer");
   a_upd_rep: assert property (p_upd_rep) else $error("pointer without report");
   a_log_upd: assert property (p_log_upd) else $error("capture without pointer");
   a_idx_hold: assert property (p_idx_hold) else $error("pointer moved");
   a_idx_legal: assert property (p_idx_legal) else $error("pointer bad");
endmodule
`default_nettype wire

// File: unc_err_bank_bench.sv
/* random bench for the error bank against a bench model.
   assumes the host model and checker files. */
`timescale 1ns/1ps
`default_nettype none
module unc_err_bank_bench;
   import unc_err_pkg::*;
   // ==========
   // signals
   logic        clk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, read_issued = 1'b0, read_completed = 1'b0;
   logic [11:0] cfg_addr = 12'h0;
   logic [3:0]  cfg_be = 4'hf;
   logic [31:0] cfg_wdata = 32'h0, severity = 32'h0, cfg_rdata, nf, nn, nl, ef = 32'h0, em = 32'h0, w;
   logic [31:0] xf = 32'h0, xn = 32'h0, xl = 32'h0, xi = 32'h0, errors = 32'h0, samples_checked = 32'h0;
   logic [9:0]  err = 10'h0;
   logic [3:0]  b;
   logic [4:0]  first_error_index;
   logic        send_fatal, send_nonfatal, log_header, update_first_error;
   integer      seed = 32'ha783f98f, cyc = 0, i, k;
   // source 10 is the read watchdog, shortened so the bench can reach it
   int          pt[11] = '{20, 20, 18, 17, 16, 16, 15, 13, 12, 4, 14};
   localparam int tmo_test = 40;
   always #2.5 clk = ~clk;
   unc_err_bank #(.timeout_limit(tmo_width'(tmo_test))) dut (.clk, .nrst, .cfg_addr, .cfg_wr, .cfg_rd,
      .cfg_be, .cfg_wdata, .cfg_rdata,
      .rx_unsupported_request(err[0]), .hp_unsupported_request(err[1]), .rx_malformed_packet(err[2]),
      .rx_buffer_overflow(err[3]), .cpl_bad_requester(err[4]), .cpl_bad_tag(err[5]),
      .hp_completer_abort(err[6]), .fc_protocol_error(err[7]), .rx_poisoned_packet(err[8]),
      .dl_protocol_error(err[9]), .read_issued, .read_completed, .severity, .send_fatal, .send_nonfatal,
      .log_header, .update_first_error, .first_error_index);
   unc_err_host host (.clk, .nrst, .send_fatal, .send_nonfatal, .log_header, .n_fatal(nf),
      .n_nonfatal(nn), .n_log(nl));
   // ==========
   // helpers
   function automatic logic [31:0] ln(input logic [3:0] e);
      return {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [3:0] e);
      @(negedge clk);
      cfg_addr = a;
      cfg_wr = wr;
      cfg_rd = !wr;
      cfg_wdata = d;
      cfg_be = e;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
   endtask
   task automatic hit(input int k);
      @(negedge clk);
      if (k < 10) err[k] = 1'b1;
      read_issued = 1'b1;
      @(negedge clk);
      err = 10'h0;
      read_issued = 1'b0;
      read_completed = (k < 10);
      // watchdog: not yet flagged halfway through the window, flagged after it
      if (k == 10) begin
         repeat (tmo_test / 2) @(negedge clk);
         acc(flags_offset, 1'b0, 32'h0, 4'hf);
         chk(cfg_rdata, ef);
         repeat (tmo_test) @(negedge clk);
      end
      @(negedge clk);
      read_completed = 1'b0;
      ef |= 32'h1 << pt[k];
      // masked sources still flag but stay silent
      if (!em[pt[k]]) begin
         if (severity[pt[k]]) xf++;
         else xn++;
         if (k inside {2, 4, 5, 6, 8}) xl++;
         xi = pt[k];
      end
      acc(flags_offset, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, ef);
      chk(nf, xf);
      chk(nn, xn);
      chk(nl, xl);
      chk(32'(first_error_index), xi);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========
   // sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         stop_test;
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      acc(flags_offset, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, flags_reset);
      acc(masks_offset, 1'b1, 32'hffff_ffff, 4'hf);
      acc(masks_offset, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, implemented_bits);
      acc(12'h10c, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, 32'h0);
      em = implemented_bits;
      for (k = 0; k < 11; k++) hit(k);
      for (i = 0; i < 60; i++) begin
         severity = $random(seed);
         w = $random(seed);
         b = 4'($random(seed));
         acc(masks_offset, 1'b1, w, b);
         em = (em & ~ln(b)) | (w & ln(b) & implemented_bits);
         acc(masks_offset, 1'b0, 32'h0, 4'hf);
         chk(cfg_rdata, em);
         hit({$random(seed)} % 11);
         acc(flags_offset, 1'b1, w, b);
         ef &= ~(w & ln(b));
      end
      // power-on reset in mid-run wipes the sticky state
      @(negedge clk);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      {ef, em, xf, xn, xl, xi} = '0;
      acc(flags_offset, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, flags_reset);
      acc(masks_offset, 1'b0, 32'h0, 4'hf);
      chk(cfg_rdata, masks_reset);
      chk(32'(first_error_index), xi);
      hit(10);
      stop_test;
   end
endmodule
bind unc_err_bank unc_err_bank_chk chk (.clk, .nrst, .cfg_rd, .rx_malformed_packet, .cpl_bad_requester,
   .cpl_bad_tag, .hp_completer_abort, .rx_poisoned_packet, .send_fatal, .send_nonfatal, .log_header,
   .update_first_error, .cfg_rdata, .severity, .first_error_index);
`default_nettype wire
